// *** phy_link_mode_control_two.v ***
// Notes on behaviour
// - Far-end drop bit kills transmitter on link loss at 100M
// - Fiber mode bit loads from strap, writable
// - Bit six shortens parallel detect, resets zero
// - Crossover modes force fast parallel detect bit
// - Extended duplex: forced partner resolves full duplex
// - Without extended duplex, use standard resolution
// - Enhanced LED lights only for 100TX full
// - Enhanced LED never blinks on activity
// - Isolate MII outputs in half or 10M
// - Bit two enables idle symbol error flag
// - Bit one disables odd nibble detection
// - Odd nibble end stretches enable with error
// - Bit zero picks RMII receive data reference
//
// Purpose: Link mode control register two with its steering logic
// Assumes: Classic Wishbone, 32-bit data, byte addresses; pins async
// Notes: Duplex standard resolution arrives ready on i_ieee_full_duplex
`timescale 1ns/1ps
`include "phy_lmc2_consts.vh"
module phy_link_mode_control_two #(
  parameter BLINK_CYC = `LMC2_BLINK_CYC
) (
  // Clock and reset
  input wire i_mclk,
  input wire i_rst_n,
  // Wishbone slave
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [7:0] i_wb_adr,
  input wire [3:0] i_wb_sel,
  input wire [31:0] i_wb_dat,
  output reg [31:0] o_wb_dat,
  output reg o_wb_ack,
  // Link state pins
  input wire i_link_up,
  input wire i_speed_100,
  input wire i_partner_forced_100tx,
  input wire i_ieee_full_duplex,
  input wire i_an_or_forced_100tx,
  input wire i_fx_strap,
  // Activity and receive pins
  input wire i_tx_activity,
  input wire i_rx_activity,
  input wire i_rx_symbol_err,
  input wire i_rx_in_idle,
  // MII transmit pins
  input wire i_tx_clk,
  input wire i_tx_en,
  input wire i_tx_er,
  // Steering outputs
  output reg o_tx_disable,
  output reg o_fx_enable,
  output reg o_fast_pd_linkup,
  output reg o_full_duplex,
  output reg o_link_led,
  output reg o_mii_isolate,
  output reg o_rx_er,
  output reg o_rmii_ref_rx_clk,
  // Transmit path out
  output wire o_tx_en,
  output wire o_tx_er
);
  wire [`LMC2_NPIN-1:0] pins_raw;
  wire [`LMC2_NPIN-1:0] s;
  reg [15:0] ctrl2_q;
  reg [15:0] ctrl2_d;
  reg [1:0] ctrl1_q;
  reg [1:0] ctrl1_d;
  reg [1:0] sticky_q;
  reg [1:0] sticky_d;
  reg [1:0] strap_cnt_q;
  reg strap_done_q;
  reg [31:0] rd_d;
  reg [31:0] blink_cnt_q;
  reg blink_q;
  reg [15:0] stat_lo;
  wire req;
  wire wr;
  wire hit_c1;
  wire hit_c2;
  wire hit_st;
  wire odd_evt;
  wire auto_fast;
  wire fd_now;
  wire link_100tx_fd;
  wire activity;
  wire idle_err;

  assign pins_raw[`LMC2_P_LINK] = i_link_up;
  assign pins_raw[`LMC2_P_SPEED] = i_speed_100;
  assign pins_raw[`LMC2_P_PFORCE] = i_partner_forced_100tx;
  assign pins_raw[`LMC2_P_IEEE_FD] = i_ieee_full_duplex;
  assign pins_raw[`LMC2_P_ANF100] = i_an_or_forced_100tx;
  assign pins_raw[`LMC2_P_TXACT] = i_tx_activity;
  assign pins_raw[`LMC2_P_RXACT] = i_rx_activity;
  assign pins_raw[`LMC2_P_SYMERR] = i_rx_symbol_err;
  assign pins_raw[`LMC2_P_IDLE] = i_rx_in_idle;
  assign pins_raw[`LMC2_P_STRAP] = i_fx_strap;
  assign pins_raw[`LMC2_P_TXCLK] = i_tx_clk;
  assign pins_raw[`LMC2_P_TXEN] = i_tx_en;
  assign pins_raw[`LMC2_P_TXER] = i_tx_er;

  pin_sync2 #(
    .WIDTH(`LMC2_NPIN)
  ) u_sync (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_async(pins_raw),
    .o_sync(s)
  );

  tx_odd_nibble_ext u_tx (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_tx_clk(s[`LMC2_P_TXCLK]),
    .i_tx_en(s[`LMC2_P_TXEN]),
    .i_tx_er(s[`LMC2_P_TXER]),
    .i_detect_en(~ctrl2_q[`LMC2_B_ODD_DIS]),
    .o_tx_en(o_tx_en),
    .o_tx_er(o_tx_er),
    .o_odd_evt(odd_evt)
  );

  // Bus decode; one access per handshake, ack cleared in the next cycle
  assign req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  assign wr = req & i_wb_we;
  assign hit_c1 = (i_wb_adr == `LMC2_CTRL1_ADR);
  assign hit_c2 = (i_wb_adr == `LMC2_CTRL2_ADR);
  assign hit_st = (i_wb_adr == `LMC2_STAT_ADR);

  assign auto_fast = ctrl1_q[`LMC2_C1_FAST_MDIX - `LMC2_C1_ROBUST_MDIX] |
                     ctrl1_q[0];
  assign link_100tx_fd = s[`LMC2_P_LINK] & s[`LMC2_P_SPEED] &
                         ~ctrl2_q[`LMC2_B_FX] & fd_now;
  assign activity = s[`LMC2_P_TXACT] | s[`LMC2_P_RXACT];
  assign idle_err = s[`LMC2_P_SYMERR] & s[`LMC2_P_IDLE] &
                    ctrl2_q[`LMC2_B_RXER_IDLE];

  // Duplex resolution
  assign fd_now = (ctrl2_q[`LMC2_B_EXT_FD] & s[`LMC2_P_ANF100] &
                   s[`LMC2_P_PFORCE] & s[`LMC2_P_SPEED]) |
                  s[`LMC2_P_IEEE_FD];

  // Control register two next value
  always @* begin
    ctrl2_d = ctrl2_q;
    if (wr && hit_c2) begin
      if (i_wb_sel[0]) begin
        ctrl2_d[7:0] = i_wb_dat[7:0];
      end
      if (i_wb_sel[1]) begin
        ctrl2_d[15:8] = i_wb_dat[15:8];
      end
    end
    // Strap value lands once the synchroniser has settled
    if (!strap_done_q && strap_cnt_q == `LMC2_STRAP_WAIT) begin
      ctrl2_d[`LMC2_B_FX] = s[`LMC2_P_STRAP];
    end
    // Hardware set beats a software clear in the same cycle
    if (auto_fast) begin
      ctrl2_d[`LMC2_B_FAST_PD] = 1'b1;
    end
  end

  always @* begin
    ctrl1_d = ctrl1_q;
    if (wr && hit_c1 && i_wb_sel[0]) begin
      ctrl1_d = i_wb_dat[`LMC2_C1_FAST_MDIX:`LMC2_C1_ROBUST_MDIX];
    end
  end

  // Sticky status, write one to clear, new event wins
  always @* begin
    sticky_d = sticky_q;
    if (wr && hit_st && i_wb_sel[1]) begin
      sticky_d = sticky_q & ~i_wb_dat[`LMC2_S_ODD:`LMC2_S_IDLE_ERR];
    end
    if (idle_err) begin
      sticky_d[0] = 1'b1;
    end
    if (odd_evt) begin
      sticky_d[1] = 1'b1;
    end
  end

  always @* begin
    stat_lo = 16'h0000;
    stat_lo[`LMC2_S_LINK] = s[`LMC2_P_LINK];
    stat_lo[`LMC2_S_SPEED] = s[`LMC2_P_SPEED];
    stat_lo[`LMC2_S_FD] = o_full_duplex;
    stat_lo[`LMC2_S_ISO] = o_mii_isolate;
    stat_lo[`LMC2_S_TXDIS] = o_tx_disable;
    stat_lo[`LMC2_S_LED] = o_link_led;
    stat_lo[`LMC2_S_ODD:`LMC2_S_IDLE_ERR] = sticky_q;
  end

  // Read mux; unmapped addresses read zero and still acknowledge
  always @* begin
    rd_d = 32'h0000_0000;
    if (hit_c2) begin
      rd_d[15:0] = ctrl2_q;
    end else if (hit_c1) begin
      rd_d[`LMC2_C1_FAST_MDIX:`LMC2_C1_ROBUST_MDIX] = ctrl1_q;
    end else if (hit_st) begin
      rd_d[15:0] = stat_lo;
    end
  end

  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else begin
      o_wb_ack <= req;
      if (req && !i_wb_we) begin
        o_wb_dat <= rd_d;
      end
    end
  end

  // Registers; bit 14 is cleared in reset until the strap is taken
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      ctrl2_q <= `LMC2_CTRL2_RST;
      ctrl1_q <= `LMC2_CTRL1_RST;
      sticky_q <= `LMC2_STAT_RST;
      strap_cnt_q <= 2'h0;
      strap_done_q <= 1'b0;
    end else begin
      ctrl2_q <= ctrl2_d;
      ctrl1_q <= ctrl1_d;
      sticky_q <= sticky_d;
      if (!strap_done_q) begin
        if (strap_cnt_q == `LMC2_STRAP_WAIT) begin
          strap_done_q <= 1'b1;
        end else begin
          strap_cnt_q <= strap_cnt_q + 2'h1;
        end
      end
    end
  end

  // Activity blink: LED dark for one half period while traffic runs
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      blink_cnt_q <= 32'h0000_0000;
      blink_q <= 1'b0;
    end else if (!activity) begin
      blink_cnt_q <= 32'h0000_0000;
      blink_q <= 1'b0;
    end else if (blink_cnt_q >= BLINK_CYC - 1) begin
      blink_cnt_q <= 32'h0000_0000;
      blink_q <= ~blink_q;
    end else begin
      blink_cnt_q <= blink_cnt_q + 32'h0000_0001;
    end
  end

  // Steering outputs, all registered
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_tx_disable <= 1'b0;
      o_fx_enable <= 1'b0;
      o_fast_pd_linkup <= 1'b0;
      o_full_duplex <= 1'b0;
      o_link_led <= 1'b0;
      o_mii_isolate <= 1'b0;
      o_rx_er <= 1'b0;
      o_rmii_ref_rx_clk <= 1'b0;
    end else begin
      o_tx_disable <= ctrl2_q[`LMC2_B_FAR_DROP] & s[`LMC2_P_SPEED] &
                      ~s[`LMC2_P_LINK];
      o_fx_enable <= ctrl2_q[`LMC2_B_FX];
      o_fast_pd_linkup <= ctrl2_q[`LMC2_B_FAST_PD];
      o_full_duplex <= s[`LMC2_P_LINK] & fd_now;
      if (ctrl2_q[`LMC2_B_ENH_LED]) begin
        o_link_led <= link_100tx_fd;
      end else begin
        o_link_led <= s[`LMC2_P_LINK] & ~blink_q;
      end
      o_mii_isolate <= ctrl2_q[`LMC2_B_ISO] & s[`LMC2_P_LINK] &
                       (~s[`LMC2_P_SPEED] | ~fd_now);
      // Symbol errors outside idle always flag; idle ones only if enabled
      o_rx_er <= (s[`LMC2_P_SYMERR] & ~s[`LMC2_P_IDLE]) | idle_err;
      o_rmii_ref_rx_clk <= ctrl2_q[`LMC2_B_RMII_CLK];
    end
  end
endmodule

// *** phy_lmc2_consts.vh ***
// Purpose: Shared constants of the link mode control block
// Assumes: Included by bare name from every design file except the synchroniser
// Notes: Word index times four gives the Wishbone byte address
`ifndef PHY_LMC2_CONSTS_VH
`define PHY_LMC2_CONSTS_VH
// Register word indices and byte addresses
`define LMC2_CTRL1_IDX 8'h09
`define LMC2_CTRL2_IDX 8'h0A
`define LMC2_STAT_IDX 8'h10
`define LMC2_CTRL1_ADR (`LMC2_CTRL1_IDX << 2)
`define LMC2_CTRL2_ADR (`LMC2_CTRL2_IDX << 2)
`define LMC2_STAT_ADR (`LMC2_STAT_IDX << 2)
// Reset values
`define LMC2_CTRL2_RST 16'h0104
`define LMC2_CTRL1_RST 2'h0
`define LMC2_STAT_RST 2'h0
// Control register two fields
`define LMC2_B_FAR_DROP 15
`define LMC2_B_FX 14
`define LMC2_B_FAST_PD 6
`define LMC2_B_EXT_FD 5
`define LMC2_B_ENH_LED 4
`define LMC2_B_ISO 3
`define LMC2_B_RXER_IDLE 2
`define LMC2_B_ODD_DIS 1
`define LMC2_B_RMII_CLK 0
// Own control register one: auto crossover modes, at their bit places
`define LMC2_C1_FAST_MDIX 6
`define LMC2_C1_ROBUST_MDIX 5
// Status register fields
`define LMC2_S_LINK 0
`define LMC2_S_SPEED 1
`define LMC2_S_FD 2
`define LMC2_S_ISO 3
`define LMC2_S_TXDIS 4
`define LMC2_S_LED 5
`define LMC2_S_IDLE_ERR 8
`define LMC2_S_ODD 9
// Positions in the synchronised pin vector
`define LMC2_NPIN 13
`define LMC2_P_LINK 0
`define LMC2_P_SPEED 1
`define LMC2_P_PFORCE 2
`define LMC2_P_IEEE_FD 3
`define LMC2_P_ANF100 4
`define LMC2_P_TXACT 5
`define LMC2_P_RXACT 6
`define LMC2_P_SYMERR 7
`define LMC2_P_IDLE 8
`define LMC2_P_STRAP 9
`define LMC2_P_TXCLK 10
`define LMC2_P_TXEN 11
`define LMC2_P_TXER 12
// Timing
`define LMC2_CLK_MHZ 10
`define LMC2_BLINK_US 20000
`define LMC2_BLINK_CYC (`LMC2_BLINK_US * `LMC2_CLK_MHZ)
`define LMC2_STRAP_WAIT 2'h3
`endif

// *** pin_sync2.v ***
// Purpose: Two flip-flop synchroniser for a vector of pins
// Assumes: Bits are independent levels
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
module pin_sync2 #(
  parameter WIDTH = 13
) (
  // Clock and reset
  input wire i_mclk,
  input wire i_rst_n,
  // Pins in, synchronised out
  input wire [WIDTH-1:0] i_async,
  output wire [WIDTH-1:0] o_sync
);
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      reg meta_q;
      reg sync_q;
      always @(posedge i_mclk) begin
        if (!i_rst_n) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end else begin
          meta_q <= i_async[g];
          sync_q <= meta_q;
        end
      end
      assign o_sync[g] = sync_q;
    end
  endgenerate
endmodule

// *** tx_odd_nibble_ext.v ***
// Purpose: Transmit enable path with odd-nibble frame end detection
// Assumes: Inputs already synchronised; TX_CLK far slower than i_mclk
// Notes: Outputs move one master clock after each TX_CLK rising edge
`timescale 1ns/1ps
`include "phy_lmc2_consts.vh"
module tx_odd_nibble_ext (
  // Clock and reset
  input wire i_mclk,
  input wire i_rst_n,
  // Synchronised transmit pins
  input wire i_tx_clk,
  input wire i_tx_en,
  input wire i_tx_er,
  // Control
  input wire i_detect_en,
  // Transmit out and event
  output reg o_tx_en,
  output reg o_tx_er,
  output reg o_odd_evt
);
  reg clk_q;
  reg en_q;
  reg parity_q;
  wire rise;
  assign rise = i_tx_clk & ~clk_q;
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      clk_q <= 1'b0;
      en_q <= 1'b0;
      parity_q <= 1'b0;
      o_tx_en <= 1'b0;
      o_tx_er <= 1'b0;
      o_odd_evt <= 1'b0;
    end else begin
      clk_q <= i_tx_clk;
      o_odd_evt <= 1'b0;
      if (rise) begin
        en_q <= i_tx_en;
        // Parity of nibbles sent so far in this frame
        parity_q <= i_tx_en ? ~parity_q : 1'b0;
        if (en_q && !i_tx_en && parity_q && i_detect_en) begin
          o_tx_en <= 1'b1;
          o_tx_er <= 1'b1;
          o_odd_evt <= 1'b1;
        end else begin
          o_tx_en <= i_tx_en;
          o_tx_er <= i_tx_er;
        end
      end
    end
  end
endmodule

// *** lmc2_checker_assertions.sv ***
// Purpose: Port-level checks of the link mode control block
// Assumes: A pin change shows at the outputs three samples after it is seen
// Notes: Register effects are tied only to recent bus writes
`timescale 1ns/1ps
module lmc2_checker (
  // Clock, reset and bus
  input wire i_mclk, i_rst_n, i_wb_cyc, i_wb_stb, i_wb_we,
  // Pins
  input wire i_link_up, i_speed_100, i_ieee_full_duplex, i_rx_symbol_err, i_rx_in_idle,
  // Outputs
  input wire o_tx_disable, o_fast_pd_linkup, o_full_duplex, o_link_led, o_mii_isolate,
  input wire o_rx_er, o_rmii_ref_rx_clk, o_tx_en, o_tx_er
);
  wire wr = i_wb_cyc & i_wb_stb & i_wb_we;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  sequence s_recent_wr;
    $past(wr, 1) || $past(wr, 2) || $past(wr, 3);
  endsequence
  sequence s_fd_cause;
    $past(i_link_up && i_ieee_full_duplex, 3);
  endsequence
  AST_TXDIS: assert property (o_tx_disable |-> $past(!i_link_up && i_speed_100, 3))
    else $error("tx off without cause");
  AST_FAST_PD: assert property ($changed(o_fast_pd_linkup) |-> s_recent_wr)
    else $error("fast link-up moved alone");
  AST_RMII: assert property ($changed(o_rmii_ref_rx_clk) |-> s_recent_wr)
    else $error("rmii reference moved alone");
  AST_FD_IEEE: assert property (s_fd_cause |-> o_full_duplex)
    else $error("full duplex lost");
  AST_LED: assert property (o_link_led |-> $past(i_link_up, 3))
    else $error("led lit without link");
  AST_ISO: assert property (o_mii_isolate |->
    $past(i_link_up, 3) && !($past(i_speed_100, 3) && o_full_duplex))
    else $error("isolate in wrong mode");
  AST_RXER: assert property ($past(i_rx_symbol_err && !i_rx_in_idle, 3) |-> o_rx_er)
    else $error("symbol error lost");
  AST_ODD: assert property (o_tx_er |-> o_tx_en)
    else $error("tx error outside enable");
endmodule

// *** mac_tx_model.sv ***
// Purpose: MAC transmit side sending nibble frames to the block
// Assumes: Eight master clocks make one 800 ns transmit clock, only around frames
// Notes: Pins move by non-blocking assignment on master clock edges
`timescale 1ns/1ps
module mac_tx_model (
  // Master clock that paces the model
  input logic i_mclk,
  // Transmit pins toward the block
  output logic o_tx_clk,
  output logic o_tx_en,
  output logic o_tx_er
);
  initial begin
    o_tx_clk = 1'b0;
    o_tx_en = 1'b0;
    o_tx_er = 1'b0;
  end
  // Three trailing clocks let the block close or stretch the frame
  task automatic send(input int n, input logic er);
    // Data moves with the falling edge so it is steady at each rise
    for (int k = 0; k < n + 3; k++) begin
      o_tx_en <= (k < n);
      o_tx_er <= er && k == 0;
      repeat (4) @(posedge i_mclk);
      o_tx_clk <= 1'b1;
      repeat (4) @(posedge i_mclk);
      o_tx_clk <= 1'b0;
    end
  endtask
endmodule

// *** phy_link_mode_control_two_tb.sv ***
// Purpose: Self-checking bench of the link mode control block
// Assumes: Ack comes one edge after a request is taken
// Notes: Blink half period cut to eight cycles to keep the run short
`timescale 1ns/1ps
module phy_link_mode_control_two_tb;
  logic i_mclk = 1'b0, i_rst_n = 1'b0, i_wb_cyc = 1'b0, i_wb_stb = 1'b0, i_wb_we = 1'b0;
  logic [7:0] i_wb_adr = 8'h00;
  logic [31:0] i_wb_dat = 32'h0, rd;
  logic [4:0] pins = 5'h00;
  logic i_fx_strap = 1'b1, act = 1'b0, i_rx_symbol_err = 1'b0, i_rx_in_idle = 1'b0;
  wire [31:0] o_wb_dat;
  wire o_wb_ack, o_tx_disable, o_fx_enable, o_fast_pd_linkup, o_full_duplex, o_link_led;
  wire o_mii_isolate, o_rx_er, o_rmii_ref_rx_clk, o_tx_en, o_tx_er, i_tx_clk, i_tx_en, i_tx_er;
  int num_errors = 0, check_count = 0, cnt;
  logic [1:0] q[$];
  // Control value, pins {link, speed, forced, ieee fd, an}, {txdis, fd, led, iso}
  logic [24:0] rows [11] = '{{16'h8104, 5'h08, 4'h8}, {16'h0104, 5'h08, 4'h0},
    {16'h8104, 5'h1A, 4'h6}, {16'h0124, 5'h1D, 4'h6}, {16'h0104, 5'h1D, 4'h2},
    {16'h0114, 5'h1D, 4'h0}, {16'h0114, 5'h1A, 4'h6}, {16'h010C, 5'h12, 4'h7},
    {16'h010C, 5'h18, 4'h3}, {16'h010C, 5'h1A, 4'h6}, {16'h0114, 5'h12, 4'h4}};
  always #50 i_mclk = ~i_mclk;
  always @(posedge i_tx_clk) begin
    repeat (5) @(posedge i_mclk);
    q.push_back({o_tx_en, o_tx_er});
  end
  mac_tx_model mac_tx_model_i (.i_mclk, .o_tx_clk(i_tx_clk), .o_tx_en(i_tx_en),
    .o_tx_er(i_tx_er));
  phy_link_mode_control_two #(.BLINK_CYC(8)) phy_link_mode_control_two_i (
    .i_mclk, .i_rst_n, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel(4'hF), .i_wb_dat,
    .o_wb_dat, .o_wb_ack, .i_link_up(pins[4]), .i_speed_100(pins[3]),
    .i_partner_forced_100tx(pins[2]), .i_ieee_full_duplex(pins[1]),
    .i_an_or_forced_100tx(pins[0]), .i_fx_strap, .i_tx_activity(act), .i_rx_activity(act),
    .i_rx_symbol_err, .i_rx_in_idle, .i_tx_clk, .i_tx_en, .i_tx_er, .o_tx_disable,
    .o_fx_enable, .o_fast_pd_linkup, .o_full_duplex, .o_link_led, .o_mii_isolate, .o_rx_er,
    .o_rmii_ref_rx_clk, .o_tx_en, .o_tx_er);
  task automatic summarize;
    if (num_errors == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    @(posedge i_mclk);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we <= we;
    i_wb_adr <= a;
    i_wb_dat <= d;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge i_mclk);
    end while (o_wb_ack !== 1'b1);
    r = o_wb_dat;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
  endtask
  task automatic frame(input int n, input logic er, input logic [15:0] c);
    logic [1:0] e;
    wb(1'b1, 8'h28, {16'h0, c}, rd);
    q.delete();
    mac_tx_model_i.send(n, er);
    repeat (8) @(posedge i_mclk);
    chk(32'(q.size()), 32'(n + 3));
    for (int k = 0; k < n + 3 && k < q.size(); k++) begin
      e = (k < n) ? {1'b1, er && k == 0} : {2{k == n && n % 2 == 1 && !c[1]}};
      chk(32'(q[k]), 32'(e));
    end
  endtask
  initial begin
    #500000;
    num_errors++;
    summarize();
  end
  initial begin
    repeat (4) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    repeat (8) @(posedge i_mclk);
    wb(1'b0, 8'h28, 32'h0, rd);
    chk(rd, 32'h4104);
    chk(32'({o_fx_enable, o_fast_pd_linkup, o_rmii_ref_rx_clk}), 32'h4);
    foreach (rows[k]) begin
      wb(1'b1, 8'h28, {16'h0, rows[k][24:9]}, rd);
      pins <= rows[k][8:4];
      repeat (4) @(posedge i_mclk);
      chk(32'({o_tx_disable, o_full_duplex, o_link_led, o_mii_isolate}), 32'(rows[k][3:0]));
      wb(1'b0, 8'h28, 32'h0, rd);
      chk(rd, {16'h0, rows[k][24:9]});
    end
    chk(32'(o_fx_enable), 32'h0);
    for (int i = 0; i < 2; i++) begin
      wb(1'b1, 8'h24, 32'h40 >> i, rd);
      wb(1'b1, 8'h28, 32'h0104, rd);
      wb(1'b0, 8'h28, 32'h0, rd);
      chk(rd, 32'h0144);
      chk(32'(o_fast_pd_linkup), 32'h1);
      wb(1'b1, 8'h24, 32'h0, rd);
      wb(1'b1, 8'h28, 32'h0104, rd);
      repeat (3) @(posedge i_mclk);
      chk(32'(o_fast_pd_linkup), 32'h0);
    end
    wb(1'b1, 8'h28, 32'h0105, rd);
    repeat (3) @(posedge i_mclk);
    chk(32'(o_rmii_ref_rx_clk), 32'h1);
    for (int i = 0; i < 3; i++) begin
      wb(1'b1, 8'h28, i == 1 ? 32'h0104 : 32'h0100, rd);
      i_rx_symbol_err <= 1'b1;
      i_rx_in_idle <= i < 2;
      repeat (4) @(posedge i_mclk);
      chk(32'(o_rx_er), 32'(i != 0));
      i_rx_symbol_err <= 1'b0;
    end
    pins <= 5'h1A;
    act <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      wb(1'b1, 8'h28, i ? 32'h0114 : 32'h0104, rd);
      repeat (3) @(posedge i_mclk);
      cnt = 0;
      repeat (40) begin
        @(posedge i_mclk);
        if (o_link_led !== 1'b1) cnt++;
      end
      chk(32'(cnt == 0), 32'(i));
    end
    act <= 1'b0;
    wb(1'b1, 8'h3C, 32'hFFFF, rd);
    wb(1'b0, 8'h3C, 32'h0, rd);
    chk(rd, 32'h0);
    frame(3, 1'b0, 16'h0104);
    frame(4, 1'b0, 16'h0104);
    frame(3, 1'b0, 16'h0106);
    frame(1, 1'b1, 16'h0104);
    wb(1'b0, 8'h40, 32'h0, rd);
    chk(rd, 32'h0327);
    wb(1'b1, 8'h40, 32'h0300, rd);
    wb(1'b0, 8'h40, 32'h0, rd);
    chk(rd, 32'h0027);
    summarize();
  end
endmodule
bind phy_link_mode_control_two lmc2_checker lmc2_checker_i (.i_mclk, .i_rst_n, .i_wb_cyc,
  .i_wb_stb, .i_wb_we, .i_link_up, .i_speed_100, .i_ieee_full_duplex, .i_rx_symbol_err,
  .i_rx_in_idle, .o_tx_disable, .o_fast_pd_linkup, .o_full_duplex, .o_link_led,
  .o_mii_isolate, .o_rx_er, .o_rmii_ref_rx_clk, .o_tx_en, .o_tx_er);
